// ===== cbd_host.sv
// Host side of the CAN controller: status/pointer, select and window SFRs,
// background DMA engine and bit timing front end.
// Assumes the core, RAM and CPU share mclk; only the bus pin is asynchronous.

module cbd_host (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_rd,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       bit_rd,
	input  wire logic       bit_wr,
	input  wire logic [7:0] bit_addr,
	input  wire logic       bit_wdata,
	input  wire logic [7:0] ctl_status,
	input  wire logic       reset_req,
	input  wire logic       bus_idle,
	input  wire logic       can_rx_pin,
	input  wire logic       core_wr,
	input  wire logic [4:0] core_idx,
	input  wire logic [7:0] core_wdata,
	input  wire logic [4:0] core_rd_idx,
	input  wire logic [7:0] ram_rdata,
	input  wire logic       ram_wait,
	output logic [7:0]      sfr_rdata_r,
	output logic            bit_rdata_r,
	output logic [7:0]      core_rdata_r,
	output logic [7:0]      ram_addr_r,
	output logic            ram_rd_r,
	output logic            ram_wr_r,
	output logic [7:0]      ram_wdata_r,
	output logic            irq_hold_r,
	output logic            rx_bit_r,
	output logic            sample_pulse_r
);
	localparam int DMA_LIMIT = cbd_pkg::DMA_MAX_CLKS;

	logic [7:0]        ctl_mem [0:cbd_pkg::CTL_REGS-1];
	logic [7:0]        select_r;
	logic [7:0]        select_nxt;
	logic [7:0]        ptr_r;
	cbd_pkg::cbd_dma_e dma_st_r;
	logic              dma_tx_r;
	logic [7:0]        src_ptr_r;
	logic [7:0]        dst_ptr_r;
	logic [3:0]        src_left_r;
	logic [3:0]        dst_left_r;
	logic              s1_r;
	logic [4:0]        s1_idx_r;
	logic              vld_r;
	logic [7:0]        ctl_q_r;
	logic              f_in_ready;
	logic              f_out_valid;
	logic              f_out_ready;
	logic [7:0]        f_out_data;
	logic              sel_wr;
	logic              win_acc;
	logic              ptr_wr;
	logic              bit_hit;
	logic [2:0]        bit_idx;
	logic              start_tx;
	logic              start_rx;
	logic              dma_start;
	logic              dma_done;
	logic              dma_abort;
	logic              issue;
	logic              pop;
	logic [3:0]        rx_dlc;
	logic [4:0]        rx_end;
	logic [3:0]        rx_cnt;
	logic [3:0]        tx_dlc;

	assign sel_wr    = sfr_wr && (sfr_addr == cbd_pkg::SFR_SELECT);
	assign win_acc   = (sfr_rd || sfr_wr) && (sfr_addr == cbd_pkg::SFR_WINDOW);
	assign ptr_wr    = sfr_wr && (sfr_addr == cbd_pkg::SFR_STATUS_PTR);
	assign bit_hit   = (bit_addr >= cbd_pkg::BIT_ADDR_BASE) && (bit_addr <= cbd_pkg::BIT_ADDR_TOP);
	assign bit_idx   = bit_addr[2:0];
	assign start_tx  = (sfr_wdata[4:0] == cbd_pkg::TX_BUF_IDX);
	assign start_rx  = (sfr_wdata[4:0] >= cbd_pkg::RX_BUF_FIRST)
		&& (sfr_wdata[4:0] <= cbd_pkg::RX_BUF_LAST);
	assign dma_start = sel_wr && sfr_wdata[cbd_pkg::SEL_DMA_BIT] && !reset_req
		&& (dma_st_r == cbd_pkg::DMA_IDLE) && (start_tx || start_rx);
	assign dma_abort = reset_req && (dma_st_r != cbd_pkg::DMA_IDLE);
	assign dma_done  = (dma_st_r == cbd_pkg::DMA_MOVE) && (dst_left_r == 4'h0);

	// length evaluation, capped at eight data bytes
	assign rx_dlc = (ctl_mem[cbd_pkg::RX_DLC_IDX][3:0] > cbd_pkg::DLC_MAX)
		? cbd_pkg::DLC_MAX : ctl_mem[cbd_pkg::RX_DLC_IDX][3:0];
	assign rx_end = cbd_pkg::RX_BUF_FIRST + 5'(cbd_pkg::DESC_BYTES) + 5'(rx_dlc);
	// from chosen buffer address to end of message
	assign rx_cnt = (sfr_wdata[4:0] < rx_end) ? 4'(rx_end - sfr_wdata[4:0]) : 4'h0;
	assign tx_dlc = (ram_rdata[3:0] > cbd_pkg::DLC_MAX) ? cbd_pkg::DLC_MAX : ram_rdata[3:0];

	assign issue = (dma_st_r == cbd_pkg::DMA_MOVE) && (src_left_r != 4'h0) && f_in_ready
		&& !(dma_tx_r && ram_wait);
	assign f_out_ready = (dma_st_r == cbd_pkg::DMA_MOVE) && (dma_tx_r || !ram_wait);
	assign pop = f_out_valid && f_out_ready;

	// Both selected transfers are at most ten bytes, so the FIFO never
	// refuses a byte already in the read pipeline.
	cbd_fifo #(
		.W     (cbd_pkg::FIFO_W),
		.DEPTH (cbd_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (mclk),
		.rst       (sys_rst),
		.clr       (dma_abort),
		.in_valid  (vld_r && (dma_st_r == cbd_pkg::DMA_MOVE)),
		.in_ready  (f_in_ready),
		.in_data   (dma_tx_r ? ram_rdata : ctl_q_r),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	always_comb
	begin
		select_nxt = select_r;
		// reset request cancels a running transfer
		if (reset_req)
			select_nxt[cbd_pkg::SEL_DMA_BIT] = 1'b0;
		if (sel_wr)
			select_nxt = {dma_start, sfr_wdata[6:0]};
		else if (win_acc && select_r[cbd_pkg::SEL_STEP_BIT])
		begin
			if (select_r[4:0] == cbd_pkg::CTL_ADDR_TOP)
			begin
				select_nxt[cbd_pkg::SEL_STEP_BIT] = 1'b0;
				select_nxt[4:0] = 5'h00;
			end
			else
				select_nxt[4:0] = select_r[4:0] + 5'h01;
		end
		if (dma_done)
			select_nxt[cbd_pkg::SEL_DMA_BIT] = 1'b0;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			select_r   <= cbd_pkg::SELECT_RST;
			irq_hold_r <= 1'b0;
		end
		else
		begin
			select_r   <= select_nxt;
			// interrupts held while DMA bit set
			irq_hold_r <= select_nxt[cbd_pkg::SEL_DMA_BIT];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			ptr_r <= cbd_pkg::PTR_RST;
		// write goes to the pointer, never to status
		else if (ptr_wr)
			ptr_r <= sfr_wdata;
		else if (bit_wr && bit_hit)
			ptr_r[bit_idx] <= bit_wdata;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sfr_rdata_r <= 8'h00;
			bit_rdata_r <= 1'b0;
		end
		else
		begin
			if (sfr_rd)
			begin
				case (sfr_addr)
					cbd_pkg::SFR_STATUS_PTR: sfr_rdata_r <= ctl_status;
					cbd_pkg::SFR_SELECT:     sfr_rdata_r <= select_r | (8'h01 << cbd_pkg::SEL_RSV_BIT);
					cbd_pkg::SFR_WINDOW:     sfr_rdata_r <= ctl_mem[select_r[4:0]];
					default:                 sfr_rdata_r <= cbd_pkg::UNMAPPED_RD;
				endcase
			end
			if (bit_rd && bit_hit)
				bit_rdata_r <= ctl_status[bit_idx];
		end
	end

	// Controller registers: window, DMA sink and core can all write in one cycle; the core write wins on a clash
	always_ff @(posedge mclk)
	begin
		if (win_acc && sfr_wr)
			ctl_mem[select_r[4:0]] <= sfr_wdata;
		if (pop && dma_tx_r)
			ctl_mem[dst_ptr_r[4:0]] <= f_out_data;
		if (core_wr)
			ctl_mem[core_idx] <= core_wdata;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			core_rdata_r <= 8'h00;
		else
			core_rdata_r <= ctl_mem[core_rd_idx];
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dma_st_r   <= cbd_pkg::DMA_IDLE;
			dma_tx_r   <= 1'b0;
			src_ptr_r  <= 8'h00;
			dst_ptr_r  <= 8'h00;
			src_left_r <= 4'h0;
			dst_left_r <= 4'h0;
		end
		else if (dma_abort)
			dma_st_r <= cbd_pkg::DMA_IDLE;
		else
		begin
			case (dma_st_r)
				cbd_pkg::DMA_IDLE:
				begin
					if (dma_start && start_tx)
					begin
						dma_st_r  <= cbd_pkg::DMA_LEN_REQ;
						dma_tx_r  <= 1'b1;
						src_ptr_r <= ptr_r;
						dst_ptr_r <= {3'h0, cbd_pkg::TX_BUF_IDX};
					end
					else if (dma_start)
					begin
						dma_st_r   <= cbd_pkg::DMA_MOVE;
						dma_tx_r   <= 1'b0;
						src_ptr_r  <= {3'h0, sfr_wdata[4:0]};
						dst_ptr_r  <= ptr_r;
						src_left_r <= rx_cnt;
						dst_left_r <= rx_cnt;
					end
				end
				cbd_pkg::DMA_LEN_REQ:
					if (!ram_wait)
						dma_st_r <= cbd_pkg::DMA_LEN_W1;
				cbd_pkg::DMA_LEN_W1:
					dma_st_r <= cbd_pkg::DMA_LEN_W2;
				cbd_pkg::DMA_LEN_W2:
				begin
					dma_st_r   <= cbd_pkg::DMA_MOVE;
					src_left_r <= cbd_pkg::DESC_BYTES + tx_dlc;
					dst_left_r <= cbd_pkg::DESC_BYTES + tx_dlc;
				end
				cbd_pkg::DMA_MOVE:
				begin
					if (issue)
					begin
						src_ptr_r  <= src_ptr_r + 8'h01;
						src_left_r <= src_left_r - 4'h1;
					end
					if (pop)
					begin
						dst_ptr_r  <= dst_ptr_r + 8'h01;
						dst_left_r <= dst_left_r - 4'h1;
					end
					if (dma_done)
						dma_st_r <= cbd_pkg::DMA_IDLE;
				end
				default: dma_st_r <= cbd_pkg::DMA_IDLE;
			endcase
		end
	end

	// one byte per clock through a two-stage read pipeline
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_r     <= 1'b0;
			s1_idx_r <= 5'h00;
			vld_r    <= 1'b0;
			ctl_q_r  <= 8'h00;
		end
		else
		begin
			s1_r     <= issue && !dma_abort;
			s1_idx_r <= src_ptr_r[4:0];
			vld_r    <= s1_r && !dma_abort;
			ctl_q_r  <= ctl_mem[s1_idx_r];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ram_rd_r    <= 1'b0;
			ram_wr_r    <= 1'b0;
			ram_addr_r  <= 8'h00;
			ram_wdata_r <= 8'h00;
		end
		else
		begin
			ram_rd_r <= 1'b0;
			ram_wr_r <= 1'b0;
			// length byte sits one past the pointer
			if ((dma_st_r == cbd_pkg::DMA_LEN_REQ) && !ram_wait && !dma_abort)
			begin
				ram_rd_r   <= 1'b1;
				ram_addr_r <= ptr_r + cbd_pkg::TX_DLC_OFS;
			end
			else if (issue && dma_tx_r && !dma_abort)
			begin
				ram_rd_r   <= 1'b1;
				ram_addr_r <= src_ptr_r;
			end
			else if (pop && !dma_tx_r && !dma_abort)
			begin
				ram_wr_r    <= 1'b1;
				ram_addr_r  <= dst_ptr_r;
				ram_wdata_r <= f_out_data;
			end
		end
	end

	// Bit timing unit
	logic             rx_s1_r;
	logic             rx_s2_r;
	logic             rx_prev_r;
	logic [1:0]       hist_r;
	cbd_pkg::cbd_seg_e seg_r;
	logic [5:0]       cnt_r;
	logic [5:0]       t1_len_r;
	logic [5:0]       t2_len_r;
	logic             synced_r;
	logic [5:0]       cfg_t1;
	logic [5:0]       cfg_t2;
	logic [5:0]       jump;
	logic [5:0]       ext;
	logic [5:0]       mag;
	logic             edge_fall;
	logic             resync;
	logic             maj;

	assign cfg_t1 = 6'(ctl_mem[cbd_pkg::BTR1_IDX][cbd_pkg::BTR1_SEG1_LSB +: 4]) + 6'h01;
	// segment after sample, 1 to 8
	assign cfg_t2 = 6'(ctl_mem[cbd_pkg::BTR1_IDX][cbd_pkg::BTR1_SEG2_LSB +: 3]) + 6'h01;
	assign jump   = 6'(ctl_mem[cbd_pkg::BTR0_IDX][cbd_pkg::BTR0_JUMP_LSB +: 2]) + 6'h01;
	assign ext    = (cnt_r < jump) ? cnt_r : jump;
	assign mag    = t2_len_r - cnt_r + 6'h01;
	// Only falling edges count, and only while the last sampled bit is 1
	assign edge_fall = rx_prev_r && !rx_s2_r && rx_bit_r;
	assign resync    = edge_fall && !bus_idle && !synced_r;
	assign maj = (hist_r[1] & hist_r[0]) | (hist_r[1] & rx_s2_r) | (hist_r[0] & rx_s2_r);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_s1_r   <= 1'b1;
			rx_s2_r   <= 1'b1;
			rx_prev_r <= 1'b1;
			hist_r    <= 2'h3;
		end
		else
		begin
			rx_s1_r   <= can_rx_pin;
			rx_s2_r   <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
			hist_r    <= {hist_r[0], rx_s2_r};
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seg_r          <= cbd_pkg::SEG_SYNC;
			cnt_r          <= 6'h00;
			t1_len_r       <= 6'h01;
			t2_len_r       <= 6'h01;
			synced_r       <= 1'b0;
			rx_bit_r       <= 1'b1;
			sample_pulse_r <= 1'b0;
		end
		else
		begin
			sample_pulse_r <= 1'b0;
			// hard sync on an idle-bus falling edge
			if (edge_fall && bus_idle)
			begin
				seg_r    <= cbd_pkg::SEG_BEFORE;
				cnt_r    <= 6'h01;
				t1_len_r <= cfg_t1;
				t2_len_r <= cfg_t2;
				synced_r <= 1'b1;
			end
			else
			begin
				case (seg_r)
					// edge slot is a single clock
					cbd_pkg::SEG_SYNC:
					begin
						seg_r    <= cbd_pkg::SEG_BEFORE;
						cnt_r    <= 6'h01;
						t1_len_r <= cfg_t1;
						t2_len_r <= cfg_t2;
						synced_r <= 1'b0;
					end
					cbd_pkg::SEG_BEFORE:
					begin
						// positive error stretches by at most the limit
						if (resync)
						begin
							t1_len_r <= t1_len_r + ext;
							synced_r <= 1'b1;
							cnt_r    <= cnt_r + 6'h01;
						end
						// sample point at end of first segment
						else if (cnt_r >= t1_len_r)
						begin
							seg_r          <= cbd_pkg::SEG_AFTER;
							cnt_r          <= 6'h01;
							sample_pulse_r <= 1'b1;
							rx_bit_r       <= ctl_mem[cbd_pkg::BTR1_IDX][cbd_pkg::BTR1_SAM_BIT]
								? maj : rx_s2_r;
						end
						else
							cnt_r <= cnt_r + 6'h01;
					end
					cbd_pkg::SEG_AFTER:
					begin
						// small negative error acts as a new edge slot
						if (resync && (mag <= jump))
						begin
							seg_r    <= cbd_pkg::SEG_BEFORE;
							cnt_r    <= 6'h01;
							t1_len_r <= cfg_t1;
							t2_len_r <= cfg_t2;
							synced_r <= 1'b1;
						end
						// bit ends after the second segment
						else if (cnt_r >= (resync ? t2_len_r - jump : t2_len_r))
							seg_r <= cbd_pkg::SEG_SYNC;
						else
						begin
							if (resync)
							begin
								t2_len_r <= t2_len_r - jump;
								synced_r <= 1'b1;
							end
							cnt_r <= cnt_r + 6'h01;
						end
					end
					default: seg_r <= cbd_pkg::SEG_SYNC;
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_status_read: assert property (
		sfr_rd && sfr_addr == cbd_pkg::SFR_STATUS_PTR |=> sfr_rdata_r == $past(ctl_status))
		else $error("status read mismatch");
	a_ptr_write: assert property (
		ptr_wr |=> ptr_r == $past(sfr_wdata) ##1 ($stable(ptr_r) || $past(ptr_wr || bit_wr)))
		else $error("pointer write lost");
	a_bit_write: assert property (
		bit_wr && bit_hit && !ptr_wr |=> ptr_r[$past(bit_idx)] == $past(bit_wdata))
		else $error("bit write lost");
	a_step_inc: assert property (
		win_acc && !sel_wr && select_r[5] && select_r[4:0] != 5'h1F && !dma_done
		|=> select_r[4:0] == $past(select_r[4:0]) + 5'h01)
		else $error("select did not step");
	a_step_wrap: assert property (
		win_acc && !sel_wr && select_r[5] && select_r[4:0] == 5'h1F |=> !select_r[5] && select_r[4:0] == 5'h00)
		else $error("select wrap wrong");
	a_dma_bound: assert property (@(posedge mclk) disable iff (sys_rst || ram_wait || reset_req)
		dma_start |=> select_r[7] ##[1:DMA_LIMIT] !select_r[7])
		else $error("DMA too slow");
	a_len_fetch: assert property (
		dma_start && start_tx && !reset_req ##1 !ram_wait && !reset_req |=> ram_rd_r && ram_addr_r == $past(ptr_r, 2) + 8'h01)
		else $error("length fetch address wrong");
	a_dma_clear: assert property (
		dma_done |=> !select_r[7] && !irq_hold_r)
		else $error("DMA bit not cleared");
	a_irq_hold: assert property (
		irq_hold_r == select_r[7] && (dma_st_r == cbd_pkg::DMA_IDLE || irq_hold_r))
		else $error("interrupt hold mismatch");
	a_no_dma_reset: assert property (
		reset_req |=> !select_r[7] && dma_st_r == cbd_pkg::DMA_IDLE)
		else $error("DMA during reset request");
	a_edge_slot: assert property (
		seg_r == cbd_pkg::SEG_SYNC |=> seg_r == cbd_pkg::SEG_BEFORE && cnt_r == 6'h01)
		else $error("edge slot not one clock");
	a_sample_end: assert property (
		sample_pulse_r |-> seg_r == cbd_pkg::SEG_AFTER && $past(seg_r) == cbd_pkg::SEG_BEFORE)
		else $error("sample not at end of first segment");
	a_ram_order: assert property (
		ram_wr_r ##1 ram_wr_r |-> ram_addr_r == $past(ram_addr_r) + 8'h01)
		else $error("RAM writes out of order");

	c_tx_dma:    cover property (dma_start && start_tx ##[1:40] dma_done);
	c_rx_dma:    cover property (dma_start && start_rx ##[1:40] dma_done);
	c_step_wrap: cover property (win_acc && select_r[5] && select_r[4:0] == 5'h1F);
	c_resync:    cover property (resync && seg_r == cbd_pkg::SEG_AFTER);

endmodule // cbd_host

// ===== cbd_pkg.sv
// Shared constants and types for the host side of the CAN controller block.
// Assumes one 250 MHz system clock and an 8-bit special function register port.
package cbd_pkg;

	localparam logic [7:0] SFR_STATUS_PTR = 8'hD8;
	localparam logic [7:0] SFR_CMD_PORT   = 8'hD9;
	localparam logic [7:0] SFR_WINDOW     = 8'hDA;
	localparam logic [7:0] SFR_SELECT     = 8'hDB;
	localparam logic [7:0] BIT_ADDR_BASE  = 8'hD8;
	localparam logic [7:0] BIT_ADDR_TOP   = 8'hDF;
	localparam logic [7:0] SELECT_RST     = 8'h64;
	localparam logic [7:0] PTR_RST        = 8'h00;
	localparam logic [7:0] UNMAPPED_RD    = 8'hFF;

	localparam int SEL_DMA_BIT  = 7;
	localparam int SEL_RSV_BIT  = 6;
	localparam int SEL_STEP_BIT = 5;
	localparam int CTL_AW       = 5;
	localparam int CTL_REGS     = 32;

	localparam logic [4:0] CTL_ADDR_TOP = 5'h1F;
	localparam logic [4:0] TX_BUF_IDX   = 5'h0A;
	localparam logic [4:0] RX_BUF_FIRST = 5'h14;
	localparam logic [4:0] RX_BUF_LAST  = 5'h1D;
	localparam logic [4:0] RX_DLC_IDX   = 5'h15;
	localparam logic [4:0] BTR0_IDX     = 5'h06;
	localparam logic [4:0] BTR1_IDX     = 5'h07;
	localparam logic [3:0] DESC_BYTES   = 4'h2;
	localparam logic [3:0] DLC_MAX      = 4'h8;
	localparam logic [7:0] TX_DLC_OFS   = 8'h01;

	// Bus timing fields inside timing registers 0 and 1
	localparam int BTR0_JUMP_LSB  = 6;
	localparam int BTR1_SEG1_LSB  = 0;
	localparam int BTR1_SEG2_LSB  = 4;
	localparam int BTR1_SAM_BIT   = 7;

	localparam int CLK_PERIOD_NS  = 4;
	localparam int INSTR_CYC_NS   = 48;
	localparam int INSTR_CYC_CLKS = INSTR_CYC_NS / CLK_PERIOD_NS;
	localparam int DMA_MAX_INSTR  = 2;
	localparam int DMA_MAX_CLKS   = DMA_MAX_INSTR * INSTR_CYC_CLKS;

	localparam int FIFO_W     = 8;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {DMA_IDLE, DMA_LEN_REQ, DMA_LEN_W1, DMA_LEN_W2, DMA_MOVE} cbd_dma_e;
	typedef enum logic [1:0] {SEG_SYNC, SEG_BEFORE, SEG_AFTER} cbd_seg_e;

endpackage

// ===== cbd_fifo.sv
// Byte FIFO in the DMA data path, valid/ready on both sides.
// Assumes a single clock; clr empties it in one cycle.
module cbd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW:0]  wr_ptr_r;
	logic [AW:0]  rd_ptr_r;
	logic         push;
	logic         pop;

	assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign out_data  = mem[rd_ptr_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else if (clr)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

endmodule // cbd_fifo

// ===== cbd_ram_model.sv
// Internal data RAM model standing behind the DMA port of the host block.
// Assumes the DMA port runs on mclk; the bench preloads and inspects mem.
module cbd_ram_model (
	input  wire logic       mclk,
	input  wire logic [7:0] ram_addr_r,
	input  wire logic       ram_rd_r,
	input  wire logic       ram_wr_r,
	input  wire logic [7:0] ram_wdata_r,
	input  wire logic       stall,
	output logic [7:0]      ram_rdata,
	output logic            ram_wait
);
	logic [7:0] mem [256];

	initial ram_rdata = 8'h00;
	assign ram_wait = stall;

	always @(posedge mclk)
	begin
		if (ram_wr_r)
			mem[ram_addr_r] <= ram_wdata_r;
		// data one cycle later
		// Between reads the data lines toggle, so a stale byte shows again only every second cycle
		ram_rdata <= ram_rd_r ? mem[ram_addr_r] : ~ram_rdata;
	end
endmodule // cbd_ram_model

// ===== cbd_host_test.sv
// Self-checking bench for the CAN host block: SFRs, stepping, DMA, bit timing.
// Assumes the RAM model sits on the DMA port and the bench plays the CPU.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end
module cbd_host_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 0;
	logic       sys_rst = 1;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, ctl_status = 8'hA5;
	logic       sfr_rd = 0, sfr_wr = 0, bit_rd = 0, bit_wr = 0, bit_wdata = 0;
	logic       reset_req = 0, bus_idle = 1, can_rx_pin = 1, core_wr = 0, stall = 0;
	logic [4:0] core_idx = 0, core_rd_idx = 0;
	logic [7:0] core_wdata = 0, ram_rdata, sfr_rdata_r, core_rdata_r;
	logic [7:0] ram_addr_r, ram_wdata_r, d;
	logic       ram_wait, bit_rdata_r, ram_rd_r, ram_wr_r;
	logic       irq_hold_r, rx_bit_r, sample_pulse_r;
	int         num_errors = 0, samples_checked = 0, n;

	cbd_host i_dut (.mclk, .sys_rst, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata, .bit_rd,
		.bit_wr, .bit_addr, .bit_wdata, .ctl_status, .reset_req, .bus_idle, .can_rx_pin,
		.core_wr, .core_idx, .core_wdata, .core_rd_idx, .ram_rdata, .ram_wait,
		.sfr_rdata_r, .bit_rdata_r, .core_rdata_r, .ram_addr_r, .ram_rd_r, .ram_wr_r,
		.ram_wdata_r, .irq_hold_r, .rx_bit_r, .sample_pulse_r);
	cbd_ram_model i_ram (.mclk, .ram_addr_r, .ram_rd_r, .ram_wr_r, .ram_wdata_r,
		.stall, .ram_rdata, .ram_wait);

	always #2 mclk = ~mclk;

	task automatic cyc();
		@(posedge mclk);
		#1;
	endtask

	// A spare cycle in front keeps strobes from being set twice in one step
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] v);
		cyc();
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = wr;
		sfr_rd = !wr;
		cyc();
		sfr_wr = 0;
		sfr_rd = 0;
	endtask

	task automatic bitop(input logic wr, input int b, input logic v);
		cyc();
		bit_addr = 8'hD8 + 8'(b);
		bit_wdata = v;
		bit_wr = wr;
		bit_rd = !wr;
		cyc();
		bit_wr = 0;
		bit_rd = 0;
	endtask

	task automatic core_rd(input int i, output logic [7:0] v);
		core_rd_idx = 5'(i);
		cyc();
		v = core_rdata_r;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_sig(input int lim, input logic want, output int k);
		k = 0;
		while ((lim > 99 ? sample_pulse_r : lim > 49 ? rx_bit_r : irq_hold_r) !== want)
		begin
			if (k == lim % 50 + 20)
			begin
				num_errors++;
				tally_and_finish();
			end
			cyc();
			k++;
		end
	endtask

	// One-clock high spike timed to land on the next sample point
	task automatic spike();
		wait_sig(130, 1, n);
		repeat (3) cyc();
		can_rx_pin = 1;
		cyc();
		can_rx_pin = 0;
		wait_sig(130, 1, n);
	endtask

	task automatic t_regs();
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, cbd_pkg::SELECT_RST)
		sfr(0, 8'hD8, 8'h00);
		`CHK(sfr_rdata_r, 8'hA5)
		sfr(1, 8'hD8, 8'h40);
		sfr(0, 8'hD8, 8'h00);
		`CHK(sfr_rdata_r, 8'hA5)
		sfr(0, 8'h80, 8'h00);
		`CHK(sfr_rdata_r, cbd_pkg::UNMAPPED_RD)
		ctl_status = 8'h96;
		for (int b = 0; b < 8; b++)
		begin
			bitop(0, b, 0);
			`CHK(bit_rdata_r, ctl_status[b])
		end
		bitop(1, 2, 1);
	endtask

	task automatic t_step();
		sfr(1, 8'hDB, 8'h2A);
		for (int i = 0; i < 3; i++)
			sfr(1, 8'hDA, 8'hC0 + 8'(i));
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, 8'h6D)
		for (int i = 0; i < 3; i++)
		begin
			core_rd(10 + i, d);
			`CHK(d, 8'hC0 + 8'(i))
		end
		sfr(1, 8'hDB, 8'h3F);
		sfr(0, 8'hDA, 8'h00);
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, 8'h40)
	endtask

	// Pointer is 44H from the bit write; length code 3 sits at 45H
	task automatic t_tx();
		for (int i = 0; i < 6; i++)
			i_ram.mem[8'h44 + 8'(i)] = 8'h10 * 8'(i) + 8'h03;
		sfr(1, 8'hDB, 8'h8A);
		cyc();
		`CHK(irq_hold_r, 1'b1)
		wait_sig(20, 0, n);
		`CHK(n < cbd_pkg::DMA_MAX_CLKS, 1'b1)
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, 8'h4A)
		for (int i = 0; i < 5; i++)
		begin
			core_rd(10 + i, d);
			`CHK(d, 8'h10 * 8'(i) + 8'h03)
		end
	endtask

	task automatic t_rx();
		core_wr = 1;
		for (int i = 0; i < 4; i++)
		begin
			core_idx = 5'h14 + 5'(i);
			core_wdata = i == 1 ? 8'h02 : 8'hA0 + 8'(i);
			cyc();
		end
		core_wr = 0;
		for (int i = 0; i < 3; i++)
			i_ram.mem[8'h80 + 8'(i)] = 8'hEE;
		sfr(1, 8'hD8, 8'h80);
		stall = 1;
		sfr(1, 8'hDB, 8'h96);
		repeat (5) cyc();
		stall = 0;
		wait_sig(40, 0, n);
		`CHK(i_ram.mem[8'h80], 8'hA2)
		`CHK(i_ram.mem[8'h81], 8'hA3)
		`CHK(i_ram.mem[8'h82], 8'hEE)
	endtask

	task automatic t_rreq();
		stall = 1;
		sfr(1, 8'hDB, 8'h8A);
		`CHK(irq_hold_r, 1'b1)
		reset_req = 1;
		cyc();
		`CHK(irq_hold_r, 1'b0)
		stall = 0;
		sfr(1, 8'hDB, 8'h8A);
		repeat (4)
		begin
			cyc();
			`CHK(irq_hold_r, 1'b0)
		end
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, 8'h4A)
		reset_req = 0;
	endtask

	// Segment one of 3 and segment two of 2 give a six-clock bit
	task automatic t_timing();
		sfr(1, 8'hDB, 8'h26);
		sfr(1, 8'hDA, 8'h40);
		sfr(1, 8'hDA, 8'h12);
		// Unset timing fields stall the counters until a fresh reset
		cyc();
		sys_rst = 1;
		repeat (2) cyc();
		sys_rst = 0;
		sfr(0, 8'hDB, 8'h00);
		`CHK(sfr_rdata_r, cbd_pkg::SELECT_RST)
		wait_sig(130, 1, n);
		cyc();
		wait_sig(130, 1, n);
		`CHK(n, 5)
		// edge two clocks into segment one
		bus_idle = 0;
		repeat (2) cyc();
		can_rx_pin = 0;
		wait_sig(130, 1, n);
		`CHK(n, 6)
		`CHK(rx_bit_r, 1'b0)
		can_rx_pin = 1;
		wait_sig(70, 1, n);
		bus_idle = 1;
		can_rx_pin = 0;
		wait_sig(70, 0, n);
		`CHK(rx_bit_r, 1'b0)
		sfr(1, 8'hDB, 8'h07);
		sfr(1, 8'hDA, 8'h92);
		spike();
		`CHK(rx_bit_r, 1'b0)
		sfr(1, 8'hDA, 8'h12);
		spike();
		`CHK(rx_bit_r, 1'b1)
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		#1;
		sys_rst = 0;
		t_regs();
		t_step();
		t_tx();
		t_rx();
		t_rreq();
		t_timing();
		tally_and_finish();
	end
endmodule // cbd_host_test
